//--- common/irf_pkg.sv
// Purpose: Shared constants for the interrupt routing and FIFO control block
// Assumes: Byte-wide registers at small indices on the device register port
// Notes: Host-side AXI4-Lite map is also held here
package irf_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam logic [4:0] REG_ROUTING = 5'h05;
  localparam logic [4:0] REG_FILL_LEVEL = 5'h06;
  localparam logic [4:0] REG_TX_SET = 5'h07;
  localparam logic [7:0] RESET_VAL = 8'h00;
  // Routing register fields
  localparam int RT_RX0_HI = 7;
  localparam int RT_RX0_LO = 6;
  localparam int RT_RX1_HI = 5;
  localparam int RT_RX1_LO = 4;
  localparam int RT_TX1 = 3;
  localparam int RT_FULL = 2;
  localparam int RT_NOT_EMPTY = 1;
  localparam int RT_OVERFLOW = 0;
  // Fill and level register fields
  localparam int FL_TRIGGER = 7;
  localparam int FL_ACTIVE = 6;
  localparam int FL_HALTED = 5;
  localparam int FL_LAUNCH = 4;
  localparam int FL_LVL_EN = 3;
  localparam int FL_LVL_FLAG = 2;
  localparam int FL_THR_HI = 1;
  localparam int FL_THR_LO = 0;
  // Transmit settings fields
  localparam int TX_PWR_HI = 7;
  localparam int TX_PWR_LO = 6;
  localparam int TX_CARRIER = 5;
  localparam int TX_SHAPING = 4;
  localparam int TX_NOISY = 1;
  localparam logic [7:0] TX_WRITE_MASK = 8'hF2;
  // Host AXI4-Lite register map
  localparam logic [3:0] AXI_CMD = 4'h0;
  localparam logic [3:0] AXI_STATUS = 4'h4;
  localparam int CMD_WRITE_BIT = 16;
  localparam int CMD_ADDR_LO = 8;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    IRF_IDLE = 2'b00,
    IRF_WAIT = 2'b01
  } irf_link_state_t;
endpackage : irf_pkg

//--- common/irf_link_if.sv
// Purpose: Register port and interrupt lines between controller and device
// Assumes: One clock for both ends
// Notes: Strobes are one-cycle pulses; read data answer one cycle later
`timescale 1ns/1ps
interface irf_link_if;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic irq_pin_a;
  logic irq_pin_b;
  modport dev (input reg_addr, input reg_wdata, input reg_wr, input reg_rd,
               output reg_rdata, output reg_rvalid, output irq_pin_a, output irq_pin_b);
  modport host (output reg_addr, output reg_wdata, output reg_wr, output reg_rd,
                input reg_rdata, input reg_rvalid, input irq_pin_a, input irq_pin_b);
endinterface : irf_link_if

//--- core/irf_device.sv
// Purpose: Interrupt line routing, FIFO flags and fill/launch control of the transceiver
// Assumes: Radio-side status arrives as synchronous levels on i_core_clk
// Notes: Interrupt lines are registered, so a selector change shows one cycle later
//
// Operation
// - Rx continuous: line A level event or sync
// - Rx buffered: line A low/byte/not-empty/sync
// - Rx continuous: line B is bit clock
// - Rx buffered: line B low/full/level event
// - Tx continuous: B bit clock, A low
// - Tx buffered: B full/halted, A not-empty
// - Full and not-empty are read-only status
// - Overrun sets flag; write one clears
// - Pattern trigger: fill only after sync match
// - Start flag sticky; write one re-arms
// - Host trigger: flag value gates filling
// - Transmit halted is read-only status
// - Launch on full or on not-empty
// - Level event only while enabled
// - Level flag sticky; write one clears
// - Threshold field selects one of three
// - Carrier-only suppresses modulation in transmit
// - Shaping bit filters transmit stream
// - Noisy bit selects synchronizer setting
// - Host writes zero to reserved bits
`timescale 1ns/1ps
module irf_device (
  input wire logic i_core_clk,
  input wire logic i_reset,
  irf_link_if.dev link,
  input wire logic i_rx_mode,
  input wire logic i_tx_mode,
  input wire logic i_buffered,
  input wire logic i_sync_match,
  input wire logic i_byte_strobe,
  input wire logic i_fifo_full,
  input wire logic i_fifo_not_empty,
  input wire logic i_fifo_overrun,
  input wire logic i_tx_halted,
  input wire logic i_bit_clock,
  input wire logic i_level_one,
  input wire logic i_level_two,
  input wire logic i_level_three,
  output logic o_fifo_clear,
  output logic o_fill_enable,
  output logic o_tx_launch,
  output logic o_mod_suppress,
  output logic o_shaping_en,
  output logic o_noisy_sync,
  output logic [1:0] o_tx_power
);
  import irf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] routing_reg, routing_next;
  logic [7:0] fill_reg, fill_next;
  logic [7:0] txset_reg, txset_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic irq_a_reg, irq_a_next;
  logic irq_b_reg, irq_b_next;
  logic clear_reg, clear_next;
  logic fill_en_reg, fill_en_next;
  logic launch_reg, launch_next, msup_reg, msup_next;
  logic level_hit;
  logic level_event;
  logic wr_route, wr_fill, wr_tx;

  assign wr_route = link.reg_wr && (link.reg_addr == REG_ROUTING);
  assign wr_fill = link.reg_wr && (link.reg_addr == REG_FILL_LEVEL);
  assign wr_tx = link.reg_wr && (link.reg_addr == REG_TX_SET);

  ////////////////////////////////////////////////////////////////////////////
  // Level comparison
  always_comb begin
    unique case (fill_reg[FL_THR_HI:FL_THR_LO])
      2'h0: level_hit = i_level_one;
      2'h1: level_hit = i_level_two;
      default: level_hit = i_level_three;
    endcase
    level_event = level_hit && fill_reg[FL_LVL_EN];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_comb begin
    routing_next = routing_reg;
    fill_next = fill_reg;
    txset_next = txset_reg;
    clear_next = 1'b0;
    if (wr_route) begin
      routing_next[RT_RX0_HI:RT_TX1] = link.reg_wdata[RT_RX0_HI:RT_TX1];
    end
    // Live status mirrored so reads see it without a second path
    routing_next[RT_FULL] = i_fifo_full;
    routing_next[RT_NOT_EMPTY] = i_fifo_not_empty;
    // Clear applied first so a same-cycle overrun survives
    if (wr_route && link.reg_wdata[RT_OVERFLOW]) begin
      routing_next[RT_OVERFLOW] = 1'b0;
      clear_next = 1'b1;
    end
    if (i_fifo_overrun) begin
      routing_next[RT_OVERFLOW] = 1'b1;
    end
    if (wr_fill) begin
      fill_next[FL_TRIGGER] = link.reg_wdata[FL_TRIGGER];
      fill_next[FL_LAUNCH:FL_LVL_EN] = link.reg_wdata[FL_LAUNCH:FL_LVL_EN];
      fill_next[FL_THR_HI:FL_THR_LO] = link.reg_wdata[FL_THR_HI:FL_THR_LO];
      if (link.reg_wdata[FL_TRIGGER]) begin
        fill_next[FL_ACTIVE] = link.reg_wdata[FL_ACTIVE];
      end else if (link.reg_wdata[FL_ACTIVE]) begin
        fill_next[FL_ACTIVE] = 1'b0;
      end
      if (link.reg_wdata[FL_LVL_FLAG]) begin
        fill_next[FL_LVL_FLAG] = 1'b0;
      end
    end
    if (!fill_next[FL_TRIGGER] && i_sync_match) begin
      fill_next[FL_ACTIVE] = 1'b1;
    end
    if (level_hit) begin
      fill_next[FL_LVL_FLAG] = 1'b1;
    end
    fill_next[FL_HALTED] = i_tx_halted;
    if (wr_tx) begin
      // Reserved positions are not stored, so they read as zero
      txset_next = link.reg_wdata & TX_WRITE_MASK;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      routing_reg <= RESET_VAL;
      fill_reg <= RESET_VAL;
      txset_reg <= RESET_VAL;
      clear_reg <= 1'b0;
    end else begin
      routing_reg <= routing_next;
      fill_reg <= fill_next;
      txset_reg <= txset_next;
      clear_reg <= clear_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  always_comb begin
    rvalid_next = link.reg_rd;
    rdata_next = 8'h00;
    if (link.reg_rd) begin
      unique case (link.reg_addr)
        REG_ROUTING: rdata_next = routing_reg;
        REG_FILL_LEVEL: rdata_next = fill_reg;
        REG_TX_SET: rdata_next = txset_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt line routing and FIFO control
  always_comb begin
    irq_a_next = 1'b0;
    irq_b_next = 1'b0;
    if (i_rx_mode && !i_buffered) begin
      irq_a_next = (routing_reg[RT_RX0_HI:RT_RX0_LO] == 2'h1) ? level_event : i_sync_match;
      irq_b_next = i_bit_clock;
    end else if (i_rx_mode) begin
      unique case (routing_reg[RT_RX0_HI:RT_RX0_LO])
        2'h0: irq_a_next = 1'b0;
        2'h1: irq_a_next = i_byte_strobe;
        2'h2: irq_a_next = i_fifo_not_empty;
        default: irq_a_next = i_sync_match;
      endcase
      unique case (routing_reg[RT_RX1_HI:RT_RX1_LO])
        2'h0: irq_b_next = 1'b0;
        2'h1: irq_b_next = i_fifo_full;
        default: irq_b_next = level_event;
      endcase
    end else if (i_tx_mode && !i_buffered) begin
      irq_b_next = i_bit_clock;
    end else if (i_tx_mode) begin
      irq_a_next = i_fifo_not_empty;
      irq_b_next = routing_reg[RT_TX1] ? i_tx_halted : i_fifo_full;
    end
    // Pattern trigger keeps the flag low until a match, gating the load
    fill_en_next = fill_reg[FL_ACTIVE];
    launch_next = i_tx_mode && i_buffered &&
                  (fill_reg[FL_LAUNCH] ? i_fifo_not_empty : i_fifo_full);
    msup_next = txset_reg[TX_CARRIER] && i_tx_mode;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
      fill_en_reg <= 1'b0;
      launch_reg <= 1'b0;
      msup_reg <= 1'b0;
    end else begin
      irq_a_reg <= irq_a_next;
      irq_b_reg <= irq_b_next;
      fill_en_reg <= fill_en_next;
      launch_reg <= launch_next;
      msup_reg <= msup_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.reg_rdata = rdata_reg;
  assign link.reg_rvalid = rvalid_reg;
  assign link.irq_pin_a = irq_a_reg;
  assign link.irq_pin_b = irq_b_reg;
  assign o_fifo_clear = clear_reg;
  assign o_fill_enable = fill_en_reg;
  assign o_tx_launch = launch_reg;
  assign o_mod_suppress = msup_reg;
  assign o_shaping_en = txset_reg[TX_SHAPING];
  assign o_noisy_sync = txset_reg[TX_NOISY];
  assign o_tx_power = txset_reg[TX_PWR_HI:TX_PWR_LO];
endmodule : irf_device

//--- core/irf_host.sv
// Purpose: Controller end: AXI4-Lite slave that issues device register accesses
// Assumes: Software polls the busy bit before issuing a new command
// Notes: Commands arriving while busy are dropped
`timescale 1ns/1ps
module irf_host (
  input wire logic i_core_clk,
  input wire logic i_reset,
  irf_link_if.host link,
  input wire logic [3:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [3:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  import irf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic aw_have_reg, aw_have_next;
  logic [3:0] aw_addr_reg, aw_addr_next;
  logic w_have_reg, w_have_next;
  logic [31:0] w_data_reg, w_data_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  irf_link_state_t state_reg, state_next;
  logic [4:0] addr_reg, addr_next;
  logic [7:0] wd_reg, wd_next;
  logic wr_reg, wr_next;
  logic rd_reg, rd_next;
  logic [7:0] result_reg, result_next;
  logic do_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  always_comb begin
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next = w_have_reg;
    w_data_next = w_data_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    do_cmd = 1'b0;
    if (i_awvalid && !aw_have_reg) begin
      aw_have_next = 1'b1;
      aw_addr_next = i_awaddr;
    end
    if (i_wvalid && !w_have_reg) begin
      w_have_next = 1'b1;
      w_data_next = i_wdata;
    end
    if (aw_have_reg && w_have_reg && !bvalid_reg) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (aw_addr_reg == AXI_CMD || aw_addr_reg == AXI_STATUS) ? AXI_OKAY : AXI_SLVERR;
      do_cmd = (aw_addr_reg == AXI_CMD);
    end else if (bvalid_reg && i_bready) begin
      bvalid_next = 1'b0;
    end
    if (i_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = AXI_OKAY;
      unique case (i_araddr)
        AXI_CMD: rdata_next = {15'h0000, wr_reg, 3'h0, addr_reg, wd_reg};
        AXI_STATUS: rdata_next = {16'h0000, result_reg, 5'h00, link.irq_pin_b, link.irq_pin_a,
                                  state_reg != IRF_IDLE};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = AXI_SLVERR;
        end
      endcase
    end else if (rvalid_reg && i_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      bvalid_reg <= 1'b0;
      bresp_reg <= AXI_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= AXI_OKAY;
    end else begin
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg <= w_have_next;
      w_data_reg <= w_data_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device register port sequencer
  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    wr_next = 1'b0;
    rd_next = 1'b0;
    result_next = result_reg;
    unique case (state_reg)
      IRF_IDLE: begin
        if (do_cmd) begin
          addr_next = w_data_reg[CMD_ADDR_LO+4:CMD_ADDR_LO];
          // Reserved transmit bits are forced to zero before reaching the device
          wd_next = (w_data_reg[CMD_ADDR_LO+4:CMD_ADDR_LO] == REG_TX_SET) ?
                    (w_data_reg[7:0] & TX_WRITE_MASK) : w_data_reg[7:0];
          if (w_data_reg[CMD_WRITE_BIT]) begin
            wr_next = 1'b1;
          end else begin
            rd_next = 1'b1;
            state_next = IRF_WAIT;
          end
        end
      end
      IRF_WAIT: begin
        if (link.reg_rvalid) begin
          result_next = link.reg_rdata;
          state_next = IRF_IDLE;
        end
      end
      default: state_next = IRF_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_reg <= IRF_IDLE;
      addr_reg <= 5'h00;
      wd_reg <= 8'h00;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      result_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      result_reg <= result_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.reg_addr = addr_reg;
  assign link.reg_wdata = wd_reg;
  assign link.reg_wr = wr_reg;
  assign link.reg_rd = rd_reg;
  assign o_awready = !aw_have_reg;
  assign o_wready = !w_have_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_arready = !rvalid_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
endmodule : irf_host

//--- test/irf_link_asserts.sv
// Purpose: Assertions on the register port that joins controller and device
// Assumes: One clock; reset synchronous, active high
// Notes: Shadow copies of the writable fields judge every read answer from the three mapped registers
`timescale 1ns/1ps
module irf_link_asserts (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic irq_pin_a,
  input wire logic irq_pin_b
);
  import irf_pkg::*;
  logic [7:0] sh5_reg, sh6_reg, sh7_reg;
  logic [4:0] ra_reg;
  // Only one command is in flight, so no write lands between a read and its answer
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sh5_reg <= RESET_VAL;
      sh6_reg <= RESET_VAL;
      sh7_reg <= RESET_VAL;
      ra_reg <= 5'h00;
    end else begin
      if (reg_wr && reg_addr == REG_ROUTING) sh5_reg <= reg_wdata;
      if (reg_wr && reg_addr == REG_FILL_LEVEL) sh6_reg <= reg_wdata;
      if (reg_wr && reg_addr == REG_TX_SET) sh7_reg <= reg_wdata;
      if (reg_rd) ra_reg <= reg_addr;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);
  sequence s_read_req;
    reg_rd;
  endsequence
  sequence s_answer_of(logic [4:0] a);
    reg_rvalid && ra_reg == a;
  endsequence
  a_read_answered: assert property (s_read_req |=> reg_rvalid)
    else $error("read strobe not answered on the next cycle");
  a_answer_caused: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without a read strobe");
  a_rdata_idle: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
    else $error("read data not idle outside an answer");
  a_tx_reserved: assert property (reg_wr && reg_addr == REG_TX_SET |-> (reg_wdata & ~TX_WRITE_MASK) == 8'h00)
    else $error("reserved transmit bits written as one");
  a_tx_readback: assert property (s_answer_of(REG_TX_SET) |->
    reg_rdata == (sh7_reg & TX_WRITE_MASK)) else $error("transmit settings read back wrong");
  a_route_kept: assert property (s_answer_of(REG_ROUTING) |-> reg_rdata[7:3] == sh5_reg[7:3])
    else $error("line selectors read back wrong");
  a_fill_kept: assert property (s_answer_of(REG_FILL_LEVEL) |->
    (reg_rdata & 8'h9B) == (sh6_reg & 8'h9B)) else $error("fill and level controls read back wrong");
  a_unmapped_zero: assert property (reg_rvalid && (ra_reg < REG_ROUTING || ra_reg > REG_TX_SET) |->
    reg_rdata == 8'h00) else $error("unmapped register read not zero");
  a_pins_reset: assert property ($fell(i_reset) |-> !irq_pin_a && !irq_pin_b)
    else $error("interrupt lines not low after reset");
endmodule : irf_link_asserts

//--- test/test_irq_routing_fifo_control.sv
// Purpose: Self-checking bench joining controller and device over the link
// Assumes: Software drives commands and polls status over AXI4-Lite
// Notes: Radio-side status lines are driven one-hot to isolate each source, except full with not-empty in the launch test
`timescale 1ns/1ps
module test_irq_routing_fifo_control;
  import irf_pkg::*;
  logic clk = 1'b0, rst = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, fclr, fill, launch, msup, shp, noisy;
  logic [1:0] bresp, rresp, pwr, pins;
  logic rx = 1'b0, tx = 1'b0, bf = 1'b0;
  // {overrun, level three, two, one, bit clock, halted, not empty, full, byte, sync}
  logic [9:0] src = 10'h000;
  int err_count = 0, n_tests = 0, clr_count = 0;
  always #20 clk = ~clk;
  always @(negedge clk) if (fclr === 1'b1) clr_count++;
  irf_link_if irf_link_if_inst ();
  assign pins = {irf_link_if_inst.irq_pin_b, irf_link_if_inst.irq_pin_a};
  irf_host irf_host_inst (.i_core_clk(clk), .i_reset(rst), .link(irf_link_if_inst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready));
  irf_device irf_device_inst (.i_core_clk(clk), .i_reset(rst), .link(irf_link_if_inst), .i_rx_mode(rx),
    .i_tx_mode(tx), .i_buffered(bf), .i_sync_match(src[0]), .i_byte_strobe(src[1]), .i_fifo_full(src[2]),
    .i_fifo_not_empty(src[3]), .i_tx_halted(src[4]), .i_bit_clock(src[5]), .i_level_one(src[6]),
    .i_level_two(src[7]), .i_level_three(src[8]), .i_fifo_overrun(src[9]), .o_fifo_clear(fclr),
    .o_fill_enable(fill), .o_tx_launch(launch), .o_mod_suppress(msup), .o_shaping_en(shp),
    .o_noisy_sync(noisy), .o_tx_power(pwr));
  irf_link_asserts irf_link_asserts_inst (.i_core_clk(clk), .i_reset(rst),
    .reg_addr(irf_link_if_inst.reg_addr), .reg_wdata(irf_link_if_inst.reg_wdata),
    .reg_wr(irf_link_if_inst.reg_wr), .reg_rd(irf_link_if_inst.reg_rd),
    .reg_rdata(irf_link_if_inst.reg_rdata), .reg_rvalid(irf_link_if_inst.reg_rvalid),
    .irq_pin_a(irf_link_if_inst.irq_pin_a), .irq_pin_b(irf_link_if_inst.irq_pin_b));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] g, input logic [31:0] e, input string w);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, w, g, e);
    end
  endtask : check
  // Handshake values are taken at the falling edge, before the edge that uses them
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic haw, hw, hb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      haw = awvalid && awready;
      hw = wvalid && wready;
      hb = bready && bvalid;
      r = bresp;
      @(posedge clk);
      if (haw) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end while (!hb);
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic har, hr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      har = arvalid && arready;
      hr = rready && rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (har) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end while (!hr);
  endtask : axi_read
  task automatic dev_op(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] s;
    logic [1:0] r;
    axi_write(AXI_CMD, {15'h0, wr, 3'h0, a, d}, r);
    do axi_read(AXI_STATUS, s, r); while (s[0] !== 1'b0);
    q = s[15:8];
  endtask : dev_op
  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    dev_op(1'b1, a, d, q);
  endtask : wreg
  task automatic rreg(input logic [4:0] a, output logic [7:0] q);
    dev_op(1'b0, a, 8'h00, q);
  endtask : rreg
  // Lines land one edge later; registered outputs show them one edge after that
  task automatic drive(input logic [9:0] s);
    @(posedge clk);
    src <= s;
    @(posedge clk);
    @(negedge clk);
  endtask : drive
  task automatic set_mode(input logic r, input logic t, input logic b);
    @(posedge clk);
    rx <= r;
    tx <= t;
    bf <= b;
  endtask : set_mode
  // Mode 0 idle, 1 rx continuous, 2 rx buffered, 3 tx continuous, 4 tx buffered; event uses level one
  function automatic logic [1:0] route(input int m, input logic [1:0] sel, input logic [9:0] s);
    case (m)
      1: return {s[5], (sel == 2'b01) ? s[6] : s[0]};
      2: return {(sel == 2'b00) ? 1'b0 : (sel == 2'b01) ? s[2] : s[6],
                 (sel == 2'b00) ? 1'b0 : (sel == 2'b01) ? s[1] : (sel == 2'b10) ? s[3] : s[0]};
      3: return {s[5], 1'b0};
      4: return {sel[0] ? s[4] : s[2], s[3]};
      default: return 2'b00;
    endcase
  endfunction : route
  ////////////////////////////////////////////////////////////
  task automatic test_reset_map;
    logic [7:0] q;
    logic [31:0] d;
    logic [1:0] r;
    for (int a = 5; a < 8; a++) begin
      rreg(5'(a), q);
      check(32'(q), 32'h0, "reset value");
    end
    rreg(5'h03, q);
    check(32'(q), 32'h0, "unmapped device read");
    axi_read(4'h8, d, r);
    check(32'(r), 32'(AXI_SLVERR), "unmapped read response");
    axi_write(4'hC, 32'h0, r);
    check(32'(r), 32'(AXI_SLVERR), "unmapped write response");
    $display("reset and map test done");
  endtask : test_reset_map
  task automatic test_routing;
    wreg(REG_FILL_LEVEL, 8'h08);
    for (int m = 0; m < 5; m++) begin
      for (int k = 0; k < 4; k++) begin
        wreg(REG_ROUTING, {k[1:0], k[1:0], k[0], 3'b000});
        set_mode(m == 1 || m == 2, m >= 3, m == 2 || m == 4);
        for (int j = 0; j < 10; j++) begin
          drive(10'h001 << j);
          check(32'(pins), 32'(route(m, k[1:0], 10'h001 << j)), "irq lines");
        end
      end
    end
    $display("routing test done");
  endtask : test_routing
  task automatic test_level;
    logic [7:0] q;
    for (int t = 0; t < 4; t++) begin
      for (int k = 6; k < 9; k++) begin
        wreg(REG_FILL_LEVEL, {6'b000011, t[1:0]});
        drive(10'h001 << k);
        drive(10'h000);
        rreg(REG_FILL_LEVEL, q);
        check(32'(q[2]), 32'((k - 6) == ((t > 1) ? 2 : t)), "level flag");
      end
    end
    wreg(REG_ROUTING, 8'h40);
    set_mode(1'b1, 1'b0, 1'b0);
    wreg(REG_FILL_LEVEL, 8'h00);
    drive(10'h040);
    check(32'(pins[0]), 32'h0, "masked level event");
    wreg(REG_FILL_LEVEL, 8'h08);
    check(32'(pins[0]), 32'h1, "enabled level event");
    $display("level test done");
  endtask : test_level
  task automatic test_overflow;
    logic [7:0] q;
    int c0;
    c0 = clr_count;
    drive(10'h200);
    drive(10'h000);
    rreg(REG_ROUTING, q);
    check(32'(q[0]), 32'h1, "overflow sticky");
    wreg(REG_ROUTING, 8'h01);
    rreg(REG_ROUTING, q);
    check(32'(q[0]), 32'h0, "overflow cleared");
    check(32'(clr_count - c0), 32'h1, "fifo clear pulses");
    $display("overflow test done");
  endtask : test_overflow
  task automatic test_fill;
    logic [7:0] q;
    wreg(REG_FILL_LEVEL, 8'h40);
    check(32'(fill), 32'h0, "no fill before match");
    drive(10'h001);
    drive(10'h000);
    rreg(REG_FILL_LEVEL, q);
    check(32'({q[6], fill}), 32'h3, "fill after match");
    wreg(REG_FILL_LEVEL, 8'h40);
    rreg(REG_FILL_LEVEL, q);
    check(32'({q[6], fill}), 32'h0, "start flag re-armed");
    wreg(REG_FILL_LEVEL, 8'hC0);
    rreg(REG_FILL_LEVEL, q);
    check(32'({q[6], fill}), 32'h3, "host starts fill");
    drive(10'h001);
    wreg(REG_FILL_LEVEL, 8'h80);
    rreg(REG_FILL_LEVEL, q);
    check(32'({q[6], fill}), 32'h0, "host stops fill");
    drive(10'h000);
    $display("fill test done");
  endtask : test_fill
  task automatic test_launch;
    logic [7:0] q;
    set_mode(1'b0, 1'b1, 1'b1);
    wreg(REG_FILL_LEVEL, 8'h00);
    drive(10'h008);
    check(32'(launch), 32'h0, "no launch until full");
    drive(10'h00C);
    check(32'(launch), 32'h1, "launch on full");
    rreg(REG_ROUTING, q);
    check(32'(q[2:1]), 32'h3, "full and not empty status");
    wreg(REG_FILL_LEVEL, 8'h10);
    drive(10'h008);
    check(32'(launch), 32'h1, "launch on not empty");
    drive(10'h010);
    check(32'(launch), 32'h0, "no launch when empty");
    rreg(REG_FILL_LEVEL, q);
    check(32'(q[5]), 32'h1, "halted status");
    rreg(REG_ROUTING, q);
    check(32'(q[2:1]), 32'h0, "empty status");
    $display("launch test done");
  endtask : test_launch
  task automatic test_txset;
    logic [7:0] q;
    wreg(REG_TX_SET, 8'hFF);
    rreg(REG_TX_SET, q);
    check(32'(q), 32'hF2, "reserved transmit bits");
    check(32'({pwr, msup, shp, noisy}), 32'h1F, "transmit options on");
    set_mode(1'b0, 1'b0, 1'b0);
    drive(10'h000);
    check(32'(msup), 32'h0, "carrier only outside transmit");
    wreg(REG_TX_SET, 8'h00);
    check(32'({pwr, msup, shp, noisy}), 32'h00, "transmit options off");
    $display("transmit settings test done");
  endtask : test_txset
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    test_reset_map;
    test_routing;
    test_level;
    test_overflow;
    test_fill;
    test_launch;
    test_txset;
    print_verdict;
  end
  // The sequence needs about a thousand cycles; this leaves a wide margin
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict;
  end
endmodule : test_irq_routing_fifo_control
